// file: shared/pcp_map.svh
// Summary of operation
// - Twelve-bit counter spans 4K-word program space.
// - Reset loads counter with top-of-memory vector.
// - Hardware interrupt jumps to fixed vector 0x008.
// - Software interrupt jumps to vector 0x002.
// - Near branch field gives low ten bits.
// - Page buffer bits 3:2 give upper bits.
// - Return restores all twelve bits from stack.
// - Return stack holds five entries.
// - Single-cycle instructions; branches take two cycles.
// - Far branches reach any address directly.
// - Page-select instruction writes lasting page bits.
// - Low reset pin holds device in reset.
// - Second interrupt input: falling edge, pull-up.
// - Counter low byte mapped at data address 0x02.
`ifndef PCP_MAP_SVH
`define PCP_MAP_SVH

// ==========================================================================
// Program space and vectors
// ==========================================================================
`define PCP_PC_W        12
`define PCP_NEAR_W      10
`define PCP_RESET_VEC   12'hfff
`define PCP_HW_VEC      12'h008
`define PCP_SW_VEC      12'h002
`define PCP_PC_ONE      12'h001

// ==========================================================================
// Page buffer and data-memory mapping
// ==========================================================================
`define PCP_PAGE_HI     3
`define PCP_PAGE_LO     2
`define PCP_PAGE_RST    8'h00
`define PCP_PCL_ADDR    8'h02

// ==========================================================================
// Return stack
// ==========================================================================
`define PCP_STK_DEPTH   5
`define PCP_STK_LAST    3'h4
`define PCP_STK_FULL    3'h5

`endif

// file: shared/pcp_pkg.sv
package pcp_pkg;

    // ======================================================================
    // Types shared by the sequencer and its return stack
    // ======================================================================

    // A full program-memory word address.
    typedef logic [11:0] pcp_addr_t;

    // Kinds of flow-affecting operation handed over by the decoder.
    typedef enum logic [3:0] {
        OP_SEQ,
        OP_NEAR_GOTO,
        OP_NEAR_CALL,
        OP_FAR_GOTO,
        OP_FAR_CALL,
        OP_RETURN,
        OP_SOFT_INT,
        OP_PAGE_SEL
    } pcp_op_t;

    // Sequencer states: normal issue, or the discarded second branch cycle.
    typedef enum logic {
        ST_RUN,
        ST_FLUSH
    } pcp_state_t;

endpackage

// file: hw/pcp_stack.sv
`timescale 1ns/1ps
`include "pcp_map.svh"

// ==========================================================================
// Five-entry hardware return stack
// ==========================================================================
// Circular storage: a push beyond five entries overwrites the oldest one,
// which matches the usual behaviour of small fixed hardware stacks and
// avoids any error path the core would have to handle.
module pcp_stack (
    input  wire logic              clk,       // Core clock.
    input  wire logic              rst_n,     // Synchronous reset, active low.
    input  wire logic              push,      // Store push_data on top.
    input  wire logic              pop,       // Drop the top entry.
    input  wire pcp_pkg::pcp_addr_t push_data, // Return address to store.
    output pcp_pkg::pcp_addr_t     top_data,  // Current top entry.
    output logic [2:0]             depth      // Number of valid entries.
);

    pcp_pkg::pcp_addr_t mem [`PCP_STK_DEPTH]; // Entry storage.
    logic [2:0]         ptr;                  // Index of the next free slot.

    // Wrap an index around the five slots.
    function automatic logic [2:0] wrap_inc(input logic [2:0] i);
        wrap_inc = (i == `PCP_STK_LAST) ? 3'h0 : i + 3'h1;
    endfunction

    function automatic logic [2:0] wrap_dec(input logic [2:0] i);
        wrap_dec = (i == 3'h0) ? `PCP_STK_LAST : i - 3'h1;
    endfunction

    // Storage write on a push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[ptr] <= push_data;
        end
    end

    // Pointer and depth bookkeeping.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr   <= 3'h0;
            depth <= 3'h0;
        end else if (push) begin
            ptr <= wrap_inc(ptr);
            if (depth != `PCP_STK_FULL) begin
                depth <= depth + 3'h1;
            end
        end else if (pop) begin
            ptr <= wrap_dec(ptr);
            if (depth != 3'h0) begin
                depth <= depth - 3'h1;
            end
        end
    end

    assign top_data = mem[wrap_dec(ptr)];

    // Depth never exceeds five and a push into a full stack keeps it full.
    a_stack_bound: assert property (@(posedge clk) disable iff (!rst_n)
        (push && depth == `PCP_STK_FULL) |=> depth == `PCP_STK_FULL)
        else $error("stack depth left five after push into full stack");

endmodule

// file: hw/pcp_core.sv
`timescale 1ns/1ps
`include "pcp_map.svh"

// ==========================================================================
// Program counter sequencer with paging and return stack
// ==========================================================================
// The decoder presents one operation per instruction slot against the
// address on FETCH_ADDR. A branch spends a second cycle in which nothing is
// accepted, standing for the discarded prefetch of the old stream.
module pcp_core (
    input  wire logic              CLK,                  // Core clock, 125 MHz.
    input  wire logic              RST_N,                // Reset pin, active low.
    input  wire logic              OP_VALID,             // Decoder offers an op.
    output logic                   OP_READY,             // Op taken this cycle.
    input  wire pcp_pkg::pcp_op_t  OP_KIND,              // Kind of operation.
    input  wire pcp_pkg::pcp_addr_t OP_TARGET,           // Branch target field.
    input  wire logic [1:0]        OP_PAGE,              // Page-select operand.
    input  wire logic              HW_IRQ_TAKE,          // Controller takes irq.
    output logic                   HW_IRQ_ACK,           // Vector taken pulse.
    input  wire logic              DMEM_WE,              // Data write strobe.
    input  wire logic [7:0]        DMEM_ADDR,            // Data write address.
    input  wire logic [7:0]        DMEM_WDATA,           // Data write value.
    output logic [7:0]             PC_LOW_BYTE,          // Counter low byte.
    output pcp_pkg::pcp_addr_t     FETCH_ADDR,           // Program fetch address.
    output logic [7:0]             PROGRAM_PAGE_BUFFER,  // Page buffer contents.
    output logic [2:0]             STACK_DEPTH,          // Valid stack entries.
    input  wire logic              SECOND_EXT_IRQ_INPUT, // Interrupt pin 1.
    output logic                   SECOND_EXT_IRQ_PULLUP,// Weak pull-up enable.
    output logic                   SECOND_EXT_IRQ_EDGE   // Falling edge pulse.
);

    // ======================================================================
    // State
    // ======================================================================
    pcp_pkg::pcp_addr_t pc;          // Program counter.
    pcp_pkg::pcp_addr_t next_pc;     // Counter value for the next cycle.
    pcp_pkg::pcp_state_t state;      // Run or branch flush.
    logic [7:0]         page_buffer; // Page buffer register.
    pcp_pkg::pcp_addr_t stack_top;   // Top of the return stack.
    logic               push;        // Stack push this cycle.
    logic               pop;         // Stack pop this cycle.
    pcp_pkg::pcp_addr_t push_data;   // Return address pushed.
    logic               accept;      // Operation taken this cycle.
    logic               irq_take;    // Interrupt vector taken this cycle.
    logic               pcl_write;   // Data write hits the low byte.
    logic               branch;      // Taken op changes the flow.
    logic [2:0]         pin_sync;    // Pin synchroniser chain.
    logic               pin_level;   // Filtered pin level.

    // Counter plus one, used for sequencing and call return addresses.
    function automatic pcp_pkg::pcp_addr_t pc_inc(input pcp_pkg::pcp_addr_t a);
        pc_inc = a + `PCP_PC_ONE;
    endfunction

    // Near target: page buffer bits on top of the ten-bit field.
    function automatic pcp_pkg::pcp_addr_t near_target(input logic [7:0] pb,
                                                       input pcp_pkg::pcp_addr_t t);
        near_target = {pb[`PCP_PAGE_HI:`PCP_PAGE_LO], t[`PCP_NEAR_W-1:0]};
    endfunction

    // ======================================================================
    // Issue control
    // ======================================================================
    // Interrupts are only taken between instructions in the run state, so a
    // half-finished branch is never split; the pending op simply waits.
    always_comb begin
        irq_take  = (state == pcp_pkg::ST_RUN) && HW_IRQ_TAKE;
        OP_READY  = (state == pcp_pkg::ST_RUN) && !HW_IRQ_TAKE;
        accept    = OP_READY && OP_VALID;
        pcl_write = accept && DMEM_WE && (DMEM_ADDR == `PCP_PCL_ADDR);
        branch    = accept && (pcl_write
                    || (OP_KIND != pcp_pkg::OP_SEQ && OP_KIND != pcp_pkg::OP_PAGE_SEL));
    end

    // Next counter value and stack traffic.
    always_comb begin
        next_pc   = pc;
        push      = 1'b0;
        pop       = 1'b0;
        push_data = pc_inc(pc);
        if (irq_take) begin
            push      = 1'b1;
            push_data = pc;              // Interrupted op runs after return.
            next_pc   = `PCP_HW_VEC;
        end else if (accept) begin
            case (OP_KIND)
                pcp_pkg::OP_NEAR_GOTO: begin
                    next_pc = near_target(page_buffer, OP_TARGET);
                end
                pcp_pkg::OP_NEAR_CALL: begin
                    push    = 1'b1;
                    next_pc = near_target(page_buffer, OP_TARGET);
                end
                pcp_pkg::OP_FAR_GOTO: begin
                    next_pc = OP_TARGET;
                end
                pcp_pkg::OP_FAR_CALL: begin
                    push    = 1'b1;
                    next_pc = OP_TARGET;
                end
                pcp_pkg::OP_RETURN: begin
                    pop     = 1'b1;
                    next_pc = stack_top;
                end
                pcp_pkg::OP_SOFT_INT: begin
                    push    = 1'b1;
                    next_pc = `PCP_SW_VEC;
                end
                default: begin
                    // Low-byte write keeps the upper bits and reloads the rest.
                    next_pc = pcl_write ? {pc[11:8], DMEM_WDATA} : pc_inc(pc);
                end
            endcase
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    // Program counter; reset starts fetching from the top of memory.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pc <= `PCP_RESET_VEC;
        end else begin
            pc <= next_pc;
        end
    end

    // Branch timing: one flush cycle after every flow change.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= pcp_pkg::ST_RUN;
        end else begin
            case (state)
                pcp_pkg::ST_RUN: begin
                    if (branch || irq_take) begin
                        state <= pcp_pkg::ST_FLUSH;
                    end
                end
                pcp_pkg::ST_FLUSH: begin
                    state <= pcp_pkg::ST_RUN;
                end
                default: begin
                    state <= pcp_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Page buffer; the page bits hold until the next page select.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            page_buffer <= `PCP_PAGE_RST;
        end else if (accept && OP_KIND == pcp_pkg::OP_PAGE_SEL) begin
            page_buffer[`PCP_PAGE_HI:`PCP_PAGE_LO] <= OP_PAGE;
        end
    end

    // Interrupt acknowledge pulse, registered for the controller.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            HW_IRQ_ACK <= 1'b0;
        end else begin
            HW_IRQ_ACK <= irq_take;
        end
    end

    // ======================================================================
    // Second external interrupt pin
    // ======================================================================
    // Three flops; the level changes only when the last two agree, which
    // also rejects a single-cycle glitch on the pin.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_sync <= 3'h7;
        end else begin
            pin_sync <= {pin_sync[1:0], SECOND_EXT_IRQ_INPUT};
        end
    end

    // Filtered level and falling edge pulse.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_level           <= 1'b1;
            SECOND_EXT_IRQ_EDGE <= 1'b0;
        end else begin
            SECOND_EXT_IRQ_EDGE <= 1'b0;
            if (pin_sync[2] == pin_sync[1]) begin
                pin_level <= pin_sync[2];
                SECOND_EXT_IRQ_EDGE <= pin_level && !pin_sync[2];
            end
        end
    end

    assign SECOND_EXT_IRQ_PULLUP = 1'b1;

    // ======================================================================
    // Return stack and outputs
    // ======================================================================
    pcp_stack u_stack (
        .clk       (CLK),
        .rst_n     (RST_N),
        .push      (push),
        .pop       (pop),
        .push_data (push_data),
        .top_data  (stack_top),
        .depth     (STACK_DEPTH)
    );

    assign FETCH_ADDR          = pc;
    assign PC_LOW_BYTE         = pc[7:0];
    assign PROGRAM_PAGE_BUFFER = page_buffer;

    // ======================================================================
    // Checks
    // ======================================================================
    sequence s_flush_then_run;
        state == pcp_pkg::ST_FLUSH ##1 state == pcp_pkg::ST_RUN;
    endsequence

    sequence s_call_taken;
        accept && (OP_KIND == pcp_pkg::OP_NEAR_CALL || OP_KIND == pcp_pkg::OP_FAR_CALL);
    endsequence

    a_reset_vector: assert property (@(posedge CLK)
        !RST_N |=> pc == `PCP_RESET_VEC)
        else $error("counter not at reset vector after reset");

    a_hw_vector: assert property (@(posedge CLK) disable iff (!RST_N)
        irq_take |=> pc == `PCP_HW_VEC && HW_IRQ_ACK)
        else $error("hardware interrupt did not reach its vector");

    a_sw_vector: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && OP_KIND == pcp_pkg::OP_SOFT_INT |=> pc == `PCP_SW_VEC)
        else $error("software interrupt did not reach its vector");

    a_near_paged: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && OP_KIND == pcp_pkg::OP_NEAR_GOTO |=>
        pc == {$past(page_buffer[3:2]), $past(OP_TARGET[9:0])})
        else $error("near jump target not paged correctly");

    a_far_target: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && OP_KIND == pcp_pkg::OP_FAR_GOTO |=> pc == $past(OP_TARGET))
        else $error("far jump missed its target");

    a_return_full: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && OP_KIND == pcp_pkg::OP_RETURN |=> pc == $past(stack_top))
        else $error("return did not restore the stacked address");

    a_call_push: assert property (@(posedge CLK) disable iff (!RST_N)
        s_call_taken |=> stack_top == $past(pc) + `PCP_PC_ONE)
        else $error("call did not stack its return address");

    a_branch_two: assert property (@(posedge CLK) disable iff (!RST_N)
        branch |=> s_flush_then_run ##0 OP_READY == !HW_IRQ_TAKE)
        else $error("branch did not take exactly two cycles");

    a_seq_single: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && !branch |=> state == pcp_pkg::ST_RUN && pc != $past(pc))
        else $error("plain instruction stalled or did not advance");

    a_page_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        accept && OP_KIND == pcp_pkg::OP_PAGE_SEL |=> page_buffer[3:2] == $past(OP_PAGE))
        else $error("page select not stored");

    a_pcl_write: assert property (@(posedge CLK) disable iff (!RST_N)
        pcl_write |=> PC_LOW_BYTE == $past(DMEM_WDATA) && pc[11:8] == $past(pc[11:8]))
        else $error("low byte write not applied");

    a_pin_fall: assert property (@(posedge CLK) disable iff (!RST_N)
        SECOND_EXT_IRQ_EDGE |-> !pin_level && $past(pin_level))
        else $error("edge pulse without a filtered falling edge");

endmodule

// file: tb/pcp_prog_mem.sv
`timescale 1ns/1ps

// ==========================================================================
// Program memory model facing the fetch address
// ==========================================================================
// A registered read of a 4K-word store whose content is a pattern of the
// address, so any fetch landing on the wrong word would show a wrong value.
module pcp_prog_mem (
    input  wire logic               clk,  // Core clock.
    input  wire pcp_pkg::pcp_addr_t addr, // Fetch address from the core.
    output logic [13:0]             word  // Instruction word at addr.
);
    // Full 4K-word space, one word for every counter value.
    logic [13:0] mem [0:4095];

    // Fill the store with an address-dependent pattern at time zero.
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 14'(i) ^ 14'h2a5a;
        end
    end

    // One-cycle read, as a synchronous on-chip store would give.
    always_ff @(posedge clk) begin
        word <= mem[addr];
    end
endmodule

// file: tb/pcp_core_test.sv
`timescale 1ns/1ps

// ==========================================================================
// Self-checking bench for the program counter sequencer
// ==========================================================================
module pcp_core_test;
    logic               CLK = 1'b0;        // Core clock, 8 ns period.
    logic               RST_N = 1'b0;      // Reset, active low.
    logic               OP_VALID = 1'b0;   // Op offered.
    logic               OP_READY;          // Op accepted.
    pcp_pkg::pcp_op_t   OP_KIND = pcp_pkg::OP_SEQ; // Op kind.
    pcp_pkg::pcp_addr_t OP_TARGET = 12'h000;      // Branch target.
    logic [1:0]         OP_PAGE = 2'h0;    // Page operand.
    logic               HW_IRQ_TAKE = 1'b0; // Interrupt request.
    logic               HW_IRQ_ACK;        // Vector taken pulse.
    logic               DMEM_WE = 1'b0;    // Data write strobe.
    logic [7:0]         DMEM_ADDR = 8'h00; // Data write address.
    logic [7:0]         DMEM_WDATA = 8'h00; // Data write value.
    logic [7:0]         PC_LOW_BYTE;       // Counter low byte.
    pcp_pkg::pcp_addr_t FETCH_ADDR;        // Fetch address.
    logic [7:0]         PROGRAM_PAGE_BUFFER; // Page buffer.
    logic [2:0]         STACK_DEPTH;       // Stack fill.
    logic               SECOND_EXT_IRQ_INPUT = 1'b1; // Pin idles high (pull-up).
    logic               SECOND_EXT_IRQ_PULLUP; // Pull-up enable.
    logic               SECOND_EXT_IRQ_EDGE;   // Falling edge pulse.
    logic [13:0]        fetched_word;      // Word from the memory model.
    int                 failures = 0;      // Mismatches seen.
    int                 checks_done = 0;   // Comparisons made.
    int                 cycles = 0;        // Cycle count for the hang limit.

    pcp_core uut (.CLK(CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_READY(OP_READY),
        .OP_KIND(OP_KIND), .OP_TARGET(OP_TARGET), .OP_PAGE(OP_PAGE),
        .HW_IRQ_TAKE(HW_IRQ_TAKE), .HW_IRQ_ACK(HW_IRQ_ACK), .DMEM_WE(DMEM_WE),
        .DMEM_ADDR(DMEM_ADDR), .DMEM_WDATA(DMEM_WDATA), .PC_LOW_BYTE(PC_LOW_BYTE),
        .FETCH_ADDR(FETCH_ADDR), .PROGRAM_PAGE_BUFFER(PROGRAM_PAGE_BUFFER),
        .STACK_DEPTH(STACK_DEPTH), .SECOND_EXT_IRQ_INPUT(SECOND_EXT_IRQ_INPUT),
        .SECOND_EXT_IRQ_PULLUP(SECOND_EXT_IRQ_PULLUP),
        .SECOND_EXT_IRQ_EDGE(SECOND_EXT_IRQ_EDGE));

    pcp_prog_mem prog (.clk(CLK), .addr(FETCH_ADDR), .word(fetched_word));

    // ======================================================================
    // Clock, hang limit and reporting
    // ======================================================================
    // Free-running clock at 125 MHz.
    initial begin
        forever #4 CLK = ~CLK;
    end

    // The whole run needs under a hundred cycles; 3000 leaves ample margin.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Compare a multi-bit result (bytes and depths are widened to twelve bits).
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Compare a one-bit result.
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // Inputs always change the same small delay after the rising edge.
    task automatic step();
        @(posedge CLK);
        #1;
    endtask

    // ======================================================================
    // Drivers
    // ======================================================================
    // Hold reset low for three cycles, then release it.
    task automatic reset_dut();
        RST_N = 1'b0;
        repeat (3) step();
        RST_N = 1'b1;
    endtask

    // Offer one op and hold it until the edge that takes it; for a branch,
    // the following cycle must refuse and the one after must accept again.
    task automatic do_op(input pcp_pkg::pcp_op_t k, input logic [11:0] tgt,
                         input logic [1:0] pg, input logic we, input logic [7:0] wa,
                         input logic [7:0] wd, input logic br);
        int n;
        n = 0;
        OP_VALID = 1'b1;
        OP_KIND = k;
        OP_TARGET = tgt;
        OP_PAGE = pg;
        DMEM_WE = we;
        DMEM_ADDR = wa;
        DMEM_WDATA = wd;
        while (OP_READY !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        step();
        OP_VALID = 1'b0;
        DMEM_WE = 1'b0;
        // An idle edge always follows, so the next call never raises the
        // strobes again in the time step that lowered them.
        chk_bit(OP_READY, !br, "flush cycle");
        step();
        chk_bit(OP_READY, 1'b1, "ready after op");
    endtask

    // Short form for ops without page operand or data write.
    task automatic op(input pcp_pkg::pcp_op_t k, input logic [11:0] tgt, input logic br);
        do_op(k, tgt, 2'h0, 1'b0, 8'h00, 8'h00, br);
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    // Reset state, also after a reset in mid-run.
    task automatic t_reset_vals();
        chk_val(FETCH_ADDR, 12'hfff, "reset vector");
        chk_val(12'(PC_LOW_BYTE), 12'h0ff, "low byte at reset");
        chk_val(12'(PROGRAM_PAGE_BUFFER), 12'h000, "page at reset");
        chk_val(12'(STACK_DEPTH), 12'h000, "depth at reset");
        chk_bit(SECOND_EXT_IRQ_PULLUP, 1'b1, "pull-up");
    endtask

    // Sequential ops each advance the counter by one and wrap at the top of the space.
    task automatic t_seq();
        op(pcp_pkg::OP_SEQ, 12'h000, 1'b0);
        chk_val(FETCH_ADDR, 12'h000, "wrap");
        op(pcp_pkg::OP_SEQ, 12'h000, 1'b0);
        chk_val(FETCH_ADDR, 12'h001, "increment");
        chk_val(fetched_word[11:0], 12'ha5b, "fetched word");
    endtask

    // Page select sticks for later near branches; upper target bits ignored.
    task automatic t_page_near();
        do_op(pcp_pkg::OP_PAGE_SEL, 12'h000, 2'h2, 1'b0, 8'h00, 8'h00, 1'b0);
        chk_val(12'(PROGRAM_PAGE_BUFFER), 12'h008, "page bits");
        op(pcp_pkg::OP_NEAR_GOTO, 12'hfab, 1'b1);
        chk_val(FETCH_ADDR, 12'hbab, "near goto");
        op(pcp_pkg::OP_NEAR_GOTO, 12'h005, 1'b1);
        chk_val(FETCH_ADDR, 12'h805, "page kept");
    endtask

    // Nested near and far calls, returns restore the whole counter.
    task automatic t_call_ret();
        op(pcp_pkg::OP_NEAR_CALL, 12'h010, 1'b1);
        chk_val(FETCH_ADDR, 12'h810, "near call");
        op(pcp_pkg::OP_FAR_CALL, 12'h73c, 1'b1);
        chk_val(FETCH_ADDR, 12'h73c, "far call");
        chk_val(12'(STACK_DEPTH), 12'h002, "two pushes");
        op(pcp_pkg::OP_RETURN, 12'h000, 1'b1);
        chk_val(FETCH_ADDR, 12'h811, "return inner");
        op(pcp_pkg::OP_RETURN, 12'h000, 1'b1);
        chk_val(FETCH_ADDR, 12'h806, "return outer");
        op(pcp_pkg::OP_FAR_GOTO, 12'h3f0, 1'b1);
        chk_val(FETCH_ADDR, 12'h3f0, "far goto");
    endtask

    // Software and hardware interrupt vectors, each returning to its origin.
    task automatic t_vectors();
        op(pcp_pkg::OP_SOFT_INT, 12'h000, 1'b1);
        chk_val(FETCH_ADDR, 12'h002, "soft vector");
        op(pcp_pkg::OP_RETURN, 12'h000, 1'b1);
        chk_val(FETCH_ADDR, 12'h3f1, "soft return");
        HW_IRQ_TAKE = 1'b1;
        OP_VALID = 1'b1;
        OP_KIND = pcp_pkg::OP_SEQ;
        #1; // Let the combinational ready settle before looking.
        chk_bit(OP_READY, 1'b0, "op held off");
        step();
        HW_IRQ_TAKE = 1'b0;
        OP_VALID = 1'b0;
        chk_val(FETCH_ADDR, 12'h008, "hw vector");
        chk_bit(HW_IRQ_ACK, 1'b1, "ack");
        chk_bit(OP_READY, 1'b0, "irq flush");
        step();
        chk_bit(HW_IRQ_ACK, 1'b0, "ack one cycle");
        op(pcp_pkg::OP_RETURN, 12'h000, 1'b1);
        chk_val(FETCH_ADDR, 12'h3f1, "irq return");
    endtask

    // Six nested calls: depth stops at five, newest entry on top.
    task automatic t_overflow();
        for (int i = 0; i < 6; i++) begin
            op(pcp_pkg::OP_FAR_CALL, 12'h100 + 12'(i * 16), 1'b1);
        end
        chk_val(12'(STACK_DEPTH), 12'h005, "depth limit");
        op(pcp_pkg::OP_RETURN, 12'h000, 1'b1);
        chk_val(FETCH_ADDR, 12'h141, "top entry");
        chk_val(12'(STACK_DEPTH), 12'h004, "pop");
    endtask

    // Writing the low byte is a branch; another address is not.
    task automatic t_low_byte();
        do_op(pcp_pkg::OP_SEQ, 12'h000, 2'h0, 1'b1, 8'h03, 8'h77, 1'b0);
        chk_val(FETCH_ADDR, 12'h142, "other address");
        do_op(pcp_pkg::OP_SEQ, 12'h000, 2'h0, 1'b1, 8'h02, 8'h5a, 1'b1);
        chk_val(FETCH_ADDR, 12'h15a, "low byte write");
        chk_val(12'(PC_LOW_BYTE), 12'h05a, "low byte read");
    endtask

    // A falling edge on the pin gives one edge pulse; a rise gives none.
    task automatic t_pin();
        int n;
        n = 0;
        SECOND_EXT_IRQ_INPUT = 1'b0;
        while (SECOND_EXT_IRQ_EDGE !== 1'b1 && n < 10) begin
            step();
            n++;
        end
        chk_bit(SECOND_EXT_IRQ_EDGE, 1'b1, "fall seen");
        step();
        chk_bit(SECOND_EXT_IRQ_EDGE, 1'b0, "pulse width");
        SECOND_EXT_IRQ_INPUT = 1'b1;
        repeat (8) begin
            step();
            chk_bit(SECOND_EXT_IRQ_EDGE, 1'b0, "no pulse on rise");
        end
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        reset_dut();
        t_reset_vals();
        t_seq();
        t_page_near();
        t_call_ret();
        t_vectors();
        t_overflow();
        t_low_byte();
        t_pin();
        reset_dut();
        t_reset_vals();
        tally_and_finish();
    end
endmodule
